// File: rtl/flash_security_access_guard.sv
// Flash access guard: routes and polices firmware and debug Flash requests
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module flash_security_access_guard #(
	parameter logic [15:0] LOCK_PAGE_BASE = `LOCK_PAGE_8K
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        power_on_reset,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cpu_valid,
	input  wire logic [1:0]  cpu_kind,
	input  wire logic [15:0] cpu_addr,
	input  wire logic [15:0] cpu_pc,
	input  wire logic [7:0]  cpu_wdata,
	input  wire logic        dbg_valid,
	input  wire logic [1:0]  dbg_op,
	input  wire logic [15:0] dbg_addr,
	input  wire logic [7:0]  dbg_wdata,
	output logic             dbg_done,
	output logic             dbg_granted,
	input  wire logic [7:0]  lock_byte_in,
	input  wire logic        flash_busy,
	output logic             flash_valid,
	output logic      [1:0]  flash_op,
	output logic      [15:0] flash_addr,
	output logic      [7:0]  flash_wdata,
	output logic             flash_from_dbg,
	output logic             xram_valid,
	output logic             xram_write,
	output logic      [15:0] xram_addr,
	output logic      [7:0]  xram_wdata,
	output logic             flash_error_reset,
	output logic             irq_hold
);

	flash_guard_pkg::guard_state_t state_q;
	flash_guard_pkg::flash_op_t    cpu_op;
	flash_guard_pkg::flash_op_t    dbg_op_e;
	flash_guard_pkg::region_t      cpu_rg;
	flash_guard_pkg::region_t      dbg_rg;
	flash_guard_pkg::region_t      pc_rg;
	flash_guard_pkg::verdict_t     cpu_v;
	flash_guard_pkg::verdict_t     dbg_v;
	logic        cpu_to_xram;
	logic        cpu_take;
	logic        dbg_take;
	logic        fw_locked;
	logic        any_locked;
	logic        lb_written;
	logic        cpu_lb_mod;
	logic        dbg_lb_mod;
	logic        lock_ready;
	logic [7:0]  lock_byte;
	logic [7:0]  lock_count;
	logic        swe_q;
	logic        see_q;
	logic        por_flag_q;
	logic        ferr_flag_q;
	logic        in_reset_q;
	logic        apb_done;
	logic        apb_first;
	logic [31:0] rd_mux;
	logic        rd_hit;

	// Lock state is frozen from reset release onward
	lock_byte_latch u_lock (
		.ref_clk      (ref_clk),
		.reset        (reset),
		.clk_en       (clk_en),
		.lock_byte_in (lock_byte_in),
		.lock_byte_q  (lock_byte),
		.lock_ready_q (lock_ready)
	);

	// Which protection class an address falls in
	function automatic flash_guard_pkg::region_t region_of(
		input logic [15:0] addr,
		input logic [7:0]  count
	);
		logic [6:0] page;
		page = addr[15:9];
		if ((addr >= `RSVD_BASE && addr <= `RSVD_LAST) ||
			page > LOCK_PAGE_BASE[15:9])
			region_of = flash_guard_pkg::RG_RESERVED;
		else if (page == LOCK_PAGE_BASE[15:9])
			region_of = flash_guard_pkg::RG_LOCK_PAGE;
		else if ({1'b0, page} < count)
			region_of = flash_guard_pkg::RG_LOCKED;
		else
			region_of = flash_guard_pkg::RG_OPEN;
	endfunction : region_of

	// Permission table; debug gets ignore where firmware would fault, except chip erase and unlocked lock page erase, which debug is allowed
	function automatic flash_guard_pkg::verdict_t decide(
		input logic                       dbg,
		input flash_guard_pkg::flash_op_t op,
		input flash_guard_pkg::region_t   rg,
		input logic                       fw_lk,
		input logic                       any_lk,
		input logic                       lb_mod
	);
		flash_guard_pkg::verdict_t deny;
		deny = dbg ? flash_guard_pkg::V_IGNORE : flash_guard_pkg::V_ERROR;
		decide = flash_guard_pkg::V_ALLOW;
		if (op == flash_guard_pkg::OP_CHIP)
			decide = dbg ? flash_guard_pkg::V_ALLOW : deny;
		else
		begin
			unique case (rg)
			flash_guard_pkg::RG_OPEN:
				decide = flash_guard_pkg::V_ALLOW;
			flash_guard_pkg::RG_LOCKED:
				decide = (!dbg && fw_lk) ? flash_guard_pkg::V_ALLOW : deny;
			flash_guard_pkg::RG_LOCK_PAGE:
				if (op == flash_guard_pkg::OP_ERASE)
					decide = (dbg && !any_lk) ? flash_guard_pkg::V_ALLOW :
						deny;
				else if (lb_mod)
					decide = deny;
				else if (any_lk && !(!dbg && fw_lk))
					decide = deny;
				else
					decide = flash_guard_pkg::V_ALLOW;
			flash_guard_pkg::RG_RESERVED:
				decide = deny;
			endcase
		end
	endfunction : decide

	// Lock summary from the sampled byte
	assign lock_count = ~lock_byte;
	assign any_locked = (lock_byte != `LOCK_ERASED);
	// Live Flash contents decide whether the byte has been written already
	assign lb_written = (lock_byte_in != `LOCK_ERASED);

	// Firmware class from the page the code runs from
	assign pc_rg     = region_of(cpu_pc, lock_count);
	assign fw_locked = (pc_rg == flash_guard_pkg::RG_LOCKED) ||
		(pc_rg == flash_guard_pkg::RG_LOCK_PAGE && any_locked);

	// Firmware request steering by instruction kind and enables
	always_comb
	begin
		cpu_op      = flash_guard_pkg::OP_READ;
		cpu_to_xram = 1'b0;
		unique case (cpu_kind)
		flash_guard_pkg::CK_MOVX_READ:
			cpu_to_xram = 1'b1;
		flash_guard_pkg::CK_MOVX_WRITE:
			if (!swe_q)
				cpu_to_xram = 1'b1;
			else if (see_q)
				cpu_op = flash_guard_pkg::OP_ERASE;
			else
				cpu_op = flash_guard_pkg::OP_WRITE;
		flash_guard_pkg::CK_MOVC_READ:
			cpu_op = flash_guard_pkg::OP_READ;
		default:
			cpu_to_xram = 1'b1; // Unused code treated as a data read
		endcase
	end

	assign dbg_op_e = flash_guard_pkg::flash_op_t'(dbg_op);
	assign cpu_rg   = region_of(cpu_addr, lock_count);
	assign dbg_rg   = region_of(dbg_addr, lock_count);
	assign cpu_lb_mod = (cpu_op == flash_guard_pkg::OP_WRITE) &&
		(cpu_addr[8:0] == `PAGE_OFS_LAST) && lb_written;
	assign dbg_lb_mod = (dbg_op_e == flash_guard_pkg::OP_WRITE) &&
		(dbg_addr[8:0] == `PAGE_OFS_LAST) && lb_written;
	assign cpu_v = decide(1'b0, cpu_op, cpu_rg, fw_locked, any_locked,
		cpu_lb_mod);
	assign dbg_v = decide(1'b1, dbg_op_e, dbg_rg, 1'b0, any_locked,
		dbg_lb_mod);

	// Firmware wins a tie; debug waits since the CPU cannot stall here
	assign cpu_take = clk_en && cpu_valid && lock_ready &&
		(state_q != flash_guard_pkg::ST_FAULT);
	assign dbg_take = clk_en && dbg_valid && !cpu_valid && lock_ready &&
		(state_q == flash_guard_pkg::ST_RUN);

	// Sequencer: debug handshake and terminal fault
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			state_q <= flash_guard_pkg::ST_RUN;
		else if (clk_en)
		begin
			unique case (state_q)
			flash_guard_pkg::ST_RUN:
				if (cpu_take && !cpu_to_xram && cpu_v == flash_guard_pkg::V_ERROR)
					state_q <= flash_guard_pkg::ST_FAULT;
				else if (dbg_take)
					state_q <= flash_guard_pkg::ST_DBG_END;
			flash_guard_pkg::ST_DBG_END:
				if (cpu_take && !cpu_to_xram && cpu_v == flash_guard_pkg::V_ERROR)
					state_q <= flash_guard_pkg::ST_FAULT;
				else if (!dbg_valid)
					state_q <= flash_guard_pkg::ST_RUN;
			flash_guard_pkg::ST_FAULT:
				state_q <= flash_guard_pkg::ST_FAULT;
			default:
				state_q <= flash_guard_pkg::ST_FAULT; // Corrupt code is unsafe
			endcase
		end
	end

	// Flash command issue; erase aligns to the page, firmware erase also drops data
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			flash_valid    <= 1'b0;
			flash_op       <= flash_guard_pkg::OP_READ;
			flash_addr     <= 16'h0000;
			flash_wdata    <= 8'h00;
			flash_from_dbg <= 1'b0;
		end
		else if (clk_en)
		begin
			flash_valid <= 1'b0;
			if (cpu_take && !cpu_to_xram && cpu_v == flash_guard_pkg::V_ALLOW)
			begin
				flash_valid    <= 1'b1;
				flash_op       <= cpu_op;
				flash_from_dbg <= 1'b0;
				if (cpu_op == flash_guard_pkg::OP_ERASE)
				begin
					flash_addr  <= {cpu_addr[15:9], `PAGE_OFS_ZERO};
					flash_wdata <= 8'h00;
				end
				else
				begin
					flash_addr  <= cpu_addr;
					flash_wdata <= cpu_wdata;
				end
			end
			else if (dbg_take && dbg_v == flash_guard_pkg::V_ALLOW)
			begin
				flash_valid    <= 1'b1;
				flash_op       <= dbg_op_e;
				flash_from_dbg <= 1'b1;
				flash_wdata    <= dbg_wdata;
				if (dbg_op_e == flash_guard_pkg::OP_ERASE)
					flash_addr <= {dbg_addr[15:9], `PAGE_OFS_ZERO};
				else
					flash_addr <= dbg_addr;
			end
		end
	end

	// Data-memory path for MOVX reads and unenabled MOVX writes
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			xram_valid <= 1'b0;
			xram_write <= 1'b0;
			xram_addr  <= 16'h0000;
			xram_wdata <= 8'h00;
		end
		else if (clk_en)
		begin
			xram_valid <= cpu_take && cpu_to_xram;
			if (cpu_take && cpu_to_xram)
			begin
				xram_write <= (cpu_kind == flash_guard_pkg::CK_MOVX_WRITE);
				xram_addr  <= cpu_addr;
				xram_wdata <= cpu_wdata;
			end
		end
	end

	// Debug answer: refusals are silent, only granted shows the difference
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			dbg_done    <= 1'b0;
			dbg_granted <= 1'b0;
		end
		else if (clk_en)
		begin
			dbg_done    <= dbg_take;
			dbg_granted <= dbg_take && dbg_v == flash_guard_pkg::V_ALLOW;
		end
	end

	// Fault request holds until the system answers with a reset
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			flash_error_reset <= 1'b0;
		else if (clk_en && cpu_take && !cpu_to_xram &&
			cpu_v == flash_guard_pkg::V_ERROR)
			flash_error_reset <= 1'b1;
	end

	// Reset cause survives the reset it caused; first reset cycle decides
	always_ff @(posedge ref_clk)
	begin
		if (power_on_reset)
		begin
			por_flag_q  <= 1'b1;
			ferr_flag_q <= 1'b0;
			in_reset_q  <= 1'b1;
		end
		else if (reset)
		begin
			in_reset_q <= 1'b1;
			if (!in_reset_q)
			begin
				ferr_flag_q <= flash_error_reset;
				por_flag_q  <= 1'b0;
			end
		end
		else if (clk_en)
			in_reset_q <= 1'b0;
	end

	// Hold interrupts while a write or erase is being launched or runs
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			irq_hold <= 1'b0;
		else if (clk_en)
			irq_hold <= flash_busy || (flash_valid &&
				flash_op != flash_guard_pkg::OP_READ);
	end

	// APB: one wait state, so pready comes from a flop
	assign apb_first = psel && penable && !pready;
	assign apb_done  = psel && penable && pready;

	// Read decode; status shows the enforced lock state
	always_comb
	begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (paddr)
		`PSC_OFFSET:
		begin
			rd_mux[`PSC_SWE_BIT] = swe_q;
			rd_mux[`PSC_SEE_BIT] = see_q;
		end
		`RSR_OFFSET:
		begin
			rd_mux[`RSR_POR_BIT]  = por_flag_q;
			rd_mux[`RSR_FERR_BIT] = ferr_flag_q;
		end
		`LKS_OFFSET:
			rd_mux[16:0] = {lock_ready, lock_count, lock_byte};
		default:
			rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= apb_first;
			pslverr <= apb_first && !rd_hit;
			if (apb_first && !pwrite)
				prdata <= rd_mux;
		end
	end

	// Program store control; no effect on the guard until written
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			swe_q <= `PSC_RESET;
			see_q <= `PSC_RESET;
		end
		else if (clk_en && apb_done && pwrite && paddr == `PSC_OFFSET)
		begin
			swe_q <= pwdata[`PSC_SWE_BIT];
			see_q <= pwdata[`PSC_SEE_BIT];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	a_xram_read_route :
	assert property (cpu_take && cpu_kind == flash_guard_pkg::CK_MOVX_READ
		|=> xram_valid && !xram_write && !flash_valid)
	else $error("MOVX read did not go to XRAM");

	a_write_needs_swe :
	assert property (cpu_take && cpu_kind == flash_guard_pkg::CK_MOVX_WRITE &&
		!swe_q |=> xram_valid && xram_write && !flash_valid)
	else $error("MOVX write reached Flash without write enable");

	a_erase_page_align :
	assert property (cpu_take && cpu_op == flash_guard_pkg::OP_ERASE &&
		!cpu_to_xram && cpu_v == flash_guard_pkg::V_ALLOW
		|=> flash_valid && flash_op == flash_guard_pkg::OP_ERASE &&
		flash_addr[8:0] == `PAGE_OFS_ZERO && flash_wdata == 8'h00)
	else $error("Page erase not issued page aligned");

	a_dbg_locked_refused :
	assert property (dbg_take && dbg_rg == flash_guard_pkg::RG_LOCKED &&
		dbg_op_e != flash_guard_pkg::OP_CHIP
		|=> dbg_done && !dbg_granted && !flash_valid)
	else $error("Debug reached a locked page");

	a_fw_reserved_fault :
	assert property (cpu_take && !cpu_to_xram &&
		cpu_rg == flash_guard_pkg::RG_RESERVED |=> flash_error_reset)
	else $error("Firmware reserved access did not fault");

	a_lock_erase_fault :
	assert property (cpu_take && !cpu_to_xram &&
		cpu_op == flash_guard_pkg::OP_ERASE &&
		cpu_rg == flash_guard_pkg::RG_LOCK_PAGE |=> flash_error_reset)
	else $error("Firmware lock page erase did not fault");

	a_dbg_no_reset :
	assert property (dbg_take |=> $stable(flash_error_reset))
	else $error("Debug request changed the fault request");

	a_fault_holds_quiet :
	assert property (flash_error_reset |=> flash_error_reset ##1
		(flash_error_reset && !flash_valid && !xram_valid))
	else $error("Fault request dropped or traffic after fault");

	a_irq_held_busy :
	assert property (clk_en && flash_busy |=> irq_hold)
	else $error("Interrupts not held during Flash operation");

	a_apb_one_wait :
	assert property (apb_first && clk_en |=> pready ##1 !pready)
	else $error("APB answer timing broken");

	c_page_erase : cover property (flash_valid &&
		flash_op == flash_guard_pkg::OP_ERASE && !flash_from_dbg);
	c_fw_fault : cover property ($rose(flash_error_reset));
	c_dbg_refused : cover property (dbg_done && !dbg_granted);
	c_chip_erase : cover property (flash_valid &&
		flash_op == flash_guard_pkg::OP_CHIP);

endmodule : flash_security_access_guard
`default_nettype wire

// File: rtl/flash_guard_consts.svh
// Offsets, field positions, reset values and address map of the Flash guard
// How it works
// - MOVX writes reach Flash only with write enable; MOVX reads go to XRAM
// - Software writes need write enable; page erase also needs erase enable
// - Write enable plus erase enable turns a MOVX write into a page erase
// - Complement of lock byte gives n; pages 0 to n-1 are locked
// - Lock byte is last user byte; its page base depends on Flash size
// - Lock byte page is open only while the lock byte reads all ones
// - Open pages outside the lock page are open to every requester
// - Locked pages: debug refused, unlocked firmware faults, locked allowed
// - Lock page read/write open if nothing locked, else locked firmware only
// - Lock byte reads follow the lock page permission pattern
// - Firmware erase of lock page faults; debug erases it only unlocked
// - With pages locked, only a debug whole-device erase clears lock page
// - A written lock byte never changes; firmware faults, debug is refused
// - Reserved area: debug refused, firmware from any page faults
// - Reserved area spans 0x1e00 to 0x1fff
// - A firmware fault resets device and leaves the Flash error flag set
// - Forbidden debug requests are dropped silently, never resetting
// - Lock state is sampled only at reset; later lock byte writes wait
// - Interrupts are held while a Flash write or erase is in progress
`ifndef FLASH_GUARD_CONSTS_SVH
`define FLASH_GUARD_CONSTS_SVH

// Register byte offsets on APB
`define PSC_OFFSET      8'h00
`define RSR_OFFSET      8'h04
`define LKS_OFFSET      8'h08

// Field positions
`define PSC_SWE_BIT     0
`define PSC_SEE_BIT     1
`define RSR_POR_BIT     1
`define RSR_FERR_BIT    6

// Reset values
`define PSC_RESET       1'b0
`define LOCK_RESET      8'h00

// Flash address map
`define LOCK_PAGE_8K    16'h1c00
`define LOCK_PAGE_4K    16'h0e00
`define LOCK_PAGE_2K    16'h0600
`define RSVD_BASE       16'h1e00
`define RSVD_LAST       16'h1fff
`define PAGE_OFS_LAST   9'h1ff
`define PAGE_OFS_ZERO   9'h000
`define LOCK_ERASED     8'hff

`endif

// File: rtl/flash_guard_pkg.sv
// Types shared by the Flash guard modules
package flash_guard_pkg;

	typedef enum logic [1:0] {
		RG_OPEN      = 2'h0,
		RG_LOCKED    = 2'h1,
		RG_LOCK_PAGE = 2'h2,
		RG_RESERVED  = 2'h3
	} region_t;

	typedef enum logic [1:0] {
		OP_READ  = 2'h0,
		OP_WRITE = 2'h1,
		OP_ERASE = 2'h2,
		OP_CHIP  = 2'h3
	} flash_op_t;

	typedef enum logic [1:0] {
		CK_MOVX_READ  = 2'h0,
		CK_MOVX_WRITE = 2'h1,
		CK_MOVC_READ  = 2'h2
	} cpu_kind_t;

	typedef enum logic [1:0] {
		V_ALLOW  = 2'h0,
		V_IGNORE = 2'h1,
		V_ERROR  = 2'h2
	} verdict_t;

	typedef enum logic [2:0] {
		ST_RUN     = 3'h1,
		ST_DBG_END = 3'h2,
		ST_FAULT   = 3'h4
	} guard_state_t;

endpackage : flash_guard_pkg

// File: rtl/lock_byte_latch.sv
// Captures the security lock byte once after each reset release
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module lock_byte_latch (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire logic [7:0] lock_byte_in,
	output logic      [7:0] lock_byte_q,
	output logic            lock_ready_q
);

	// Reads as fully locked until captured, so nothing leaks before sampling
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			lock_byte_q  <= `LOCK_RESET;
			lock_ready_q <= 1'b0;
		end
		else if (clk_en && !lock_ready_q)
		begin
			lock_byte_q  <= lock_byte_in;
			lock_ready_q <= 1'b1;
		end
	end

	a_lock_frozen :
	assert property (@(posedge ref_clk) disable iff (reset)
		lock_ready_q && $past(lock_ready_q) |-> $stable(lock_byte_q))
	else $error("Enforced lock byte changed without a reset");

endmodule : lock_byte_latch
`default_nettype wire

// File: tb/flash_array_model.sv
// Behavioural Flash array at the guard's far side: lock byte and busy time
`timescale 1ns/10ps
`default_nettype none
module flash_array_model #(
	parameter logic [15:0] LOCK_ADDR   = 16'h1dff,
	parameter int          BUSY_CYCLES = 3
) (
	input  wire logic        ref_clk,
	input  wire logic        load,
	input  wire logic [7:0]  load_val,
	input  wire logic        flash_valid,
	input  wire logic [1:0]  flash_op,
	input  wire logic [15:0] flash_addr,
	input  wire logic [7:0]  flash_wdata,
	output logic      [7:0]  lock_byte_in,
	output logic             flash_busy
);
	int   busy_cnt = 0;
	logic on_lock_page;

	assign on_lock_page = (flash_addr[15:9] == LOCK_ADDR[15:9]);
	// Programming only clears bits; only an erase sets them back to one
	always_ff @(posedge ref_clk)
	begin
		if (load)
			lock_byte_in <= load_val;
		else if (flash_valid && flash_op == 2'h3)
			lock_byte_in <= 8'hff;
		else if (flash_valid && flash_op == 2'h2 && on_lock_page)
			lock_byte_in <= 8'hff;
		else if (flash_valid && flash_op == 2'h1 && flash_addr == LOCK_ADDR)
			lock_byte_in <= lock_byte_in & flash_wdata;
	end
	// Writes and erases keep the array busy; reads answer at once
	always_ff @(posedge ref_clk)
	begin
		if (flash_valid && flash_op != 2'h0)
			busy_cnt <= BUSY_CYCLES;
		else if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
	end
	assign flash_busy = (busy_cnt > 0);
endmodule : flash_array_model
`default_nettype wire

// File: tb/flash_security_access_guard_tb.sv
// Self-checking bench for the Flash access guard
`timescale 1ns/10ps
`default_nettype none
`include "flash_guard_consts.svh"
module flash_security_access_guard_tb;
	localparam logic [15:0] LB = `LOCK_PAGE_8K;
	logic        ref_clk = 1'b0, reset = 1'b1, power_on_reset = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, slv;
	logic        cpu_valid = 1'b0, dbg_valid = 1'b0, load = 1'b1;
	logic        clk_en = 1'b1;
	logic [1:0]  cpu_kind = 2'h0, dbg_op = 2'h0, flash_op;
	logic [15:0] cpu_addr = 16'h0, cpu_pc = 16'h0, dbg_addr = 16'h0;
	logic [7:0]  cpu_wdata = 8'h00, dbg_wdata = 8'h00, load_val = 8'hff;
	logic        dbg_done, dbg_granted, flash_busy, flash_valid;
	logic        flash_from_dbg, xram_valid, xram_write;
	logic        flash_error_reset, irq_hold;
	logic [15:0] flash_addr, xram_addr;
	logic [7:0]  flash_wdata, xram_wdata, lock_byte_in;
	logic [7:0]  nlk = 8'h00;
	int          miscompares = 0, n_compared = 0, cycles = 0;
	int          seed = 32'h3b699f73;

	flash_security_access_guard #(.LOCK_PAGE_BASE(LB)) dut (.ref_clk, .reset,
		.power_on_reset, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cpu_valid, .cpu_kind, .cpu_addr,
		.cpu_pc, .cpu_wdata, .dbg_valid, .dbg_op, .dbg_addr, .dbg_wdata,
		.dbg_done, .dbg_granted, .lock_byte_in, .flash_busy, .flash_valid,
		.flash_op, .flash_addr, .flash_wdata, .flash_from_dbg, .xram_valid,
		.xram_write, .xram_addr, .xram_wdata, .flash_error_reset, .irq_hold);
	flash_array_model #(.LOCK_ADDR(LB + 16'h01ff)) fam (.ref_clk, .load,
		.load_val, .flash_valid, .flash_op, .flash_addr, .flash_wdata,
		.lock_byte_in, .flash_busy);

	always #4 ref_clk = ~ref_clk;
	// A hang anywhere ends in the same closing report
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// Request held until pready is sampled high, then released
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Lock state is resampled on every release, so refresh the count
	task automatic do_reset(input logic por);
		@(posedge ref_clk);
		reset <= 1'b1;
		power_on_reset <= por;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		power_on_reset <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nlk = ~lock_byte_in;
	endtask : do_reset

	// Waits for flash_busy low; only the global cycle ceiling ends a hung wait
	task automatic wait_idle();
		while (flash_busy !== 1'b0)
			@(posedge ref_clk);
	endtask : wait_idle

	// Verdict for a read or write: 0 allow, 1 ignore, 2 error reset
	function automatic logic [1:0] exp_v(input logic [15:0] a, pc,
		input logic dbg);
		logic lkpc;
		lkpc = ({1'b0, pc[15:9]} < nlk) || (pc[15:9] == LB[15:9] && nlk != 0);
		if (a >= `RSVD_BASE)
			return dbg ? 2'h1 : 2'h2;
		if (nlk == 8'h00 || ({1'b0, a[15:9]} >= nlk && a[15:9] != LB[15:9]))
			return 2'h0;
		return dbg ? 2'h1 : (lkpc ? 2'h0 : 2'h2);
	endfunction : exp_v

	// v: 0 Flash command op, 1 XRAM access, 2 error reset
	task automatic fw(input logic [1:0] kd, input logic [15:0] a, pc,
		input logic [1:0] v, input logic [1:0] op);
		wait_idle();
		@(posedge ref_clk);
		cpu_valid <= 1'b1;
		cpu_kind <= kd;
		cpu_addr <= a;
		cpu_pc <= pc;
		cpu_wdata <= 8'hfd;
		@(posedge ref_clk);
		cpu_valid <= 1'b0;
		#1;
		chk({flash_valid, xram_valid, flash_error_reset},
			{v == 2'h0, v == 2'h1, v == 2'h2});
		if (v == 2'h1)
			chk({xram_write, xram_addr, xram_wdata},
				{kd == 2'h1, a, 8'hfd});
		if (v == 2'h0)
			chk({flash_from_dbg, flash_op, flash_addr, flash_wdata},
				{1'b0, op, op == 2'h2 ? {a[15:9], 9'h000} : a,
				op == 2'h2 ? 8'h00 : 8'hfd});
		// A launched write or erase must hold interrupts one cycle later
		if (v == 2'h0 && op != 2'h0)
		begin
			@(posedge ref_clk);
			#1;
			chk(irq_hold, 1'b1);
		end
		if (v == 2'h2)
		begin
			do_reset(1'b0);
			apb(1'b0, `RSR_OFFSET, 32'h0);
			chk(rd & 32'h42, 32'h40);
		end
	endtask : fw

	task automatic dbg(input logic [1:0] op, input logic [15:0] a,
		input logic g);
		wait_idle();
		@(posedge ref_clk);
		dbg_valid <= 1'b1;
		dbg_op <= op;
		dbg_addr <= a;
		dbg_wdata <= 8'(cycles);
		do
		begin
			@(posedge ref_clk);
			#1;
		end
		while (dbg_done !== 1'b1);
		chk({dbg_done, dbg_granted, flash_valid, flash_error_reset},
			{1'b1, g, g, 1'b0});
		if (g)
			chk({flash_from_dbg, flash_op}, {1'b1, op});
		@(posedge ref_clk);
		dbg_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : dbg

	initial
	begin
		logic [15:0] a;
		logic [15:0] pc;
		@(posedge ref_clk);
		load <= 1'b0;
		do_reset(1'b1);
		apb(1'b1, `RSR_OFFSET, 32'h2);
		apb(1'b0, `RSR_OFFSET, 32'h0);
		chk(rd & 32'h42, 32'h02);
		apb(1'b0, `PSC_OFFSET, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({slv, rd}, {1'b1, 32'h0});
		apb(1'b1, `PSC_OFFSET, 32'h3);
		apb(1'b0, `PSC_OFFSET, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, `PSC_OFFSET, 32'h0);
		fw(2'h0, 16'h0a00, 16'h0a00, 2'h1, 2'h0);
		// Clock enable low: a waiting request must not be taken
		@(posedge ref_clk);
		clk_en <= 1'b0;
		cpu_valid <= 1'b1;
		cpu_kind <= 2'h0;
		cpu_addr <= 16'h0a00;
		repeat (2) @(posedge ref_clk);
		clk_en <= 1'b1;
		#1;
		chk(xram_valid, 1'b0);
		@(posedge ref_clk);
		cpu_valid <= 1'b0;
		#1;
		chk(xram_valid, 1'b1);
		fw(2'h1, 16'h0a00, 16'h0a00, 2'h1, 2'h0);
		fw(2'h2, 16'h1dff, 16'h0a00, 2'h0, 2'h0);
		dbg(2'h0, 16'h1dff, 1'b1);
		dbg(2'h2, 16'h1c00, 1'b1);
		apb(1'b1, `PSC_OFFSET, 32'h1);
		fw(2'h0, 16'h0a00, 16'h0a00, 2'h1, 2'h0);
		fw(2'h1, 16'h1dff, 16'h0a00, 2'h0, 2'h1);
		fw(2'h2, 16'h0000, 16'h0a00, 2'h0, 2'h0);
		dbg(2'h1, 16'h1dff, 1'b0);
		apb(1'b1, `PSC_OFFSET, 32'h3);
		fw(2'h1, 16'h0a37, 16'h0a00, 2'h0, 2'h2);
		fw(2'h1, 16'h1c00, 16'h0a00, 2'h2, 2'h0);
		apb(1'b0, `LKS_OFFSET, 32'h0);
		chk(rd & 32'h1ffff, 32'h102fd);
		fw(2'h2, 16'h0000, 16'h0a00, 2'h2, 2'h0);
		fw(2'h2, 16'h0100, 16'h0010, 2'h0, 2'h0);
		fw(2'h2, 16'h1dff, 16'h0a00, 2'h2, 2'h0);
		fw(2'h2, 16'h1e00, 16'h0010, 2'h2, 2'h0);
		dbg(2'h0, 16'h0200, 1'b0);
		dbg(2'h0, 16'h1c00, 1'b0);
		dbg(2'h2, 16'h1c00, 1'b0);
		dbg(2'h1, 16'h1e00, 1'b0);
		dbg(2'h1, 16'h0400, 1'b1);
		apb(1'b1, `PSC_OFFSET, 32'h1);
		fw(2'h1, 16'h1dff, 16'h0010, 2'h2, 2'h0);
		apb(1'b1, `PSC_OFFSET, 32'h3);
		fw(2'h1, 16'h1c00, 16'h0010, 2'h2, 2'h0);
		repeat (12)
		begin
			a = 16'($random(seed)) & 16'h1fff;
			pc = 16'($random(seed)) & 16'h1bff;
			dbg(2'h0, a, exp_v(a, pc, 1'b1) == 2'h0);
			fw(2'h2, a, pc, exp_v(a, pc, 1'b0), 2'h0);
		end
		dbg(2'h3, 16'h0000, 1'b1);
		tally_and_finish();
	end
endmodule : flash_security_access_guard_tb
`default_nettype wire
